/* File: hdl/dsc_cpu_status_datapath.sv */
// How it works
// - Program counter is 23 bits, stepping over 24-bit instruction words.
// - One cycle per instruction except divide; flow changes, double move, table take two.
// - Sixteen 16-bit working registers; the last is the stack pointer.
// - Each cycle: one X read, register read, memory write, fetch.
// - 64 KB data space with separate X and Y address generators.
// - Ordinary ops use X only; multiply-accumulate reads both X and Y.
// - Modulo addressing on X and Y; X modulo works for any op.
// - X generator offers bit-reversed post-increment for FFT reordering.
// - Upper data half maps onto program space via 8-bit page.
// - 17x17 multiplier, 40-bit adder, two saturating 40-bit accumulators.
// - Barrel shifter moves a 40-bit value up to 31 places left or 32 right.
// - Multiply-accumulate fetches two operands while multiplying registers.
// - Signed, unsigned, mixed multiplies; fractional -1 times -1 is exact.
// - Divides take 19 cycles in total and survive interrupts intact.
// - Block loops and repeats cost no overhead and are interruptible.
// - Status bits 15 and 14 show accumulator A and B overflow.
// - Status bits 13 and 12 are sticky saturation flags, clear-only.
// - Status bit 11 is the OR of both overflow flags.
// - Status bit 10 ORs sticky flags; clearing it clears both.
// - Status bit 9 is high while a block loop runs.
// - Status bit 8 holds half carry from bit 3 or bit 7.
// - Priority bits join the top bit; read-only while nesting disabled.
// - Status bit 4 is high while a repeat loop runs.
// - Status bit 0 holds carry out of the result's top bit.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_core_params.svh"

module dsc_cpu_status_datapath import dsc_core_pkg::*; #(
  parameter int DIV_CYCLES = `DIV_CYCLES,
  parameter int DIV_STEPS  = `DIV_STEPS
) (
  input  wire logic        clk_in,                 // 50 MHz core clock
  input  wire logic        rstn_in,                // Sync reset, low
  input  wire logic        psel_in,                // APB select
  input  wire logic        penable_in,             // APB access phase
  input  wire logic        pwrite_in,              // APB write
  input  wire logic [11:0] paddr_in,               // APB byte address
  input  wire logic [31:0] pwdata_in,              // APB write data
  output logic      [31:0] prdata_out,             // APB read data
  output logic             pready_out,             // APB ready
  output logic             pslverr_out,            // APB error
  input  wire logic        cmd_valid_in,           // Decoded op valid
  input  wire cmd_s        cmd_in,                 // Decoded op
  output logic             cmd_ready_out,          // Op accepted
  input  wire logic        irq_in,                 // Interrupt hold
  output logic [`PC_W-1:0] fetch_addr_out,         // Instruction fetch
  output logic      [15:0] x_rd_addr_out,          // X read address
  input  wire logic [15:0] x_rd_data_in,           // X read data
  output logic      [15:0] y_rd_addr_out,          // Y read address
  input  wire logic [15:0] y_rd_data_in,           // Y read data
  output logic [`PC_W-1:0] psv_addr_out,           // Program data address
  input  wire logic [15:0] psv_data_in,            // Program data low word
  output mem_wr_s          wr_out,                 // Data memory write
  output logic      [15:0] cpu_status_word_out,    // Status word
  output logic       [3:0] cpu_priority_level_out, // Priority level
  output logic             user_irq_enable_out     // User irqs allowed
);

  core_state_e      state_reg;
  cmd_s             cur_reg;
  logic [15:0]      wreg_reg [16];
  logic [`PC_W-1:0] pc_reg, tgt_reg, do_start_reg, do_end_reg;
  logic [15:0]      do_cnt_reg, rpt_cnt_reg, ctrl_reg;
  logic [31:0]      xmod_reg, ymod_reg, agu_reg;
  logic [`ACC_W-1:0] acc_a_reg, acc_b_reg;
  logic             ovf_a_reg, ovf_b_reg, sat_a_reg, sat_b_reg;
  logic             dc_reg, n_reg, ov_reg, z_reg, c_reg;
  logic [2:0]       ipl_reg;
  logic [4:0]       div_cnt_reg;
  logic [16:0]      div_rem_reg;
  logic [15:0]      div_q_reg, div_den_reg;
  logic             div_qneg_reg, div_rneg_reg;
  logic [31:0]      prdata_reg;
  logic             err_reg;
  mem_wr_s          wr_reg;

  cmd_s             cx;
  logic             fire, done, multi, hold_pc, loop_back;
  logic [15:0]      ra, rb, beff, cxv, xa, xnext, ynext, xdata, res16;
  logic [16:0]      sum, div_try;
  logic signed [16:0] ma, mb;
  logic signed [33:0] prod;
  logic [`ACC_W-1:0] prod40, acc_cur, acc_raw, acc_res;
  logic [5:0]       sh_neg;
  logic             acc_op, acc_ovf, acc_sat, sub;
  logic [15:0]      sr;
  logic [31:0]      rd_val, div_n;
  logic             rd_hit, apb_wr;
  logic [11:0]      pa;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
  endfunction

  function automatic logic [15:0] mod_step(input logic [15:0] a,
                                           input logic [31:0] win,
                                           input logic        en);
    mod_step = (en && a == win[`MOD_END]) ? win[`MOD_START]
                                          : a + `WORD_BYTES;
  endfunction

  assign cx = (state_reg == S_RUN) ? cmd_in : cur_reg;
  assign fire = (state_reg == S_RUN) && cmd_valid_in;
  assign cmd_ready_out = (state_reg == S_RUN);
  assign multi = cx.op inside {OP_BRA, OP_CALL, OP_MOVD, OP_TBL};
  assign done = (fire && !multi && cx.op != OP_DIV)
             || (state_reg == S_WAIT)
             || (state_reg == S_DIV && !irq_in
                 && div_cnt_reg == 5'(DIV_CYCLES - 1));
  assign ra = wreg_reg[cx.rs];
  assign rb = wreg_reg[cx.rt];

  always_comb begin
    xa = ra;
    if (cx.op == OP_MAC) xa = wreg_reg[`MAC_XP_IDX];
    if (state_reg == S_WAIT && cx.op == OP_MOVD) xa = ra + `WORD_BYTES;
    if (agu_reg[`AG_BREV] && cx.op == OP_LD)
      xnext = rev16(rev16(xa) + rev16(agu_reg[`AG_BMOD]));
    else
      xnext = mod_step(xa, xmod_reg, agu_reg[`AG_XMOD]);
    ynext = mod_step(wreg_reg[`MAC_YP_IDX], ymod_reg, agu_reg[`AG_YMOD]);
  end
  assign x_rd_addr_out = xa;
  // Y side used only by MAC
  assign y_rd_addr_out = wreg_reg[`MAC_YP_IDX];
  assign psv_addr_out = (cx.op == OP_TBL) ? {ctrl_reg[`CT_PAGE], ra[14:0]}
                                          : {ctrl_reg[`CT_PAGE], xa[14:0]};
  assign xdata = (xa[15] && ctrl_reg[`CT_PSV]) ? psv_data_in : x_rd_data_in;
  assign fetch_addr_out = pc_reg;

  // Flag ALU; C and DC read as inverted borrow on subtract
  always_comb begin
    sub = (cx.op == OP_SUB);
    beff = sub ? ~rb : rb;
    sum = {1'b0, ra} + {1'b0, beff} + {16'h0000, sub};
    cxv = ra ^ beff ^ sum[15:0];
    res16 = cx.byte_mode ? {ra[15:8], sum[7:0]} : sum[15:0];
  end

  always_comb begin
    ma = $signed({cx.sign_s & ra[15], ra});
    mb = $signed({cx.sign_t & rb[15], rb});
    prod = ma * mb;
    prod40 = {{6{prod[33]}}, prod};
    if (ctrl_reg[`CT_FRAC]) prod40 = {prod40[`ACC_W-2:0], 1'b0};
  end

  always_comb begin
    acc_cur = cx.acc_b ? acc_b_reg : acc_a_reg;
    sh_neg = 6'h00 - cx.lit[5:0];
    if (cx.op == OP_SFT)
      acc_raw = cx.lit[5] ? `ACC_W'($signed(acc_cur) >>> sh_neg)
                          : acc_cur << cx.lit[5:0];
    else
      acc_raw = acc_cur + prod40;
    acc_op = fire && (cx.op == OP_MAC || cx.op == OP_SFT);
    acc_ovf = !(&acc_raw[39:31] || !(|acc_raw[39:31]));
    acc_sat = acc_ovf && (cx.acc_b ? ctrl_reg[`CT_SAT_B]
                                   : ctrl_reg[`CT_SAT_A]);
    acc_res = acc_sat ? (acc_raw[39] ? `SAT_NEG : `SAT_POS) : acc_raw;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
    end else if (acc_op && cx.acc_b) begin
      acc_b_reg <= acc_res;
    end else if (acc_op) begin
      acc_a_reg <= acc_res;
    end
  end

  // Divider state is frozen while irq_in is high
  assign div_try = {div_rem_reg[15:0], div_q_reg[15]} - {1'b0, div_den_reg};
  assign div_n = cx.wide ? {wreg_reg[cx.rs + 4'h1], ra}
                         : {{16{cx.sign_s & ra[15]}}, ra};
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg    <= S_RUN;
      cur_reg      <= '0;
      div_cnt_reg  <= '0;
      div_rem_reg  <= '0;
      div_q_reg    <= '0;
      div_den_reg  <= '0;
      div_qneg_reg <= 1'b0;
      div_rneg_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_RUN: if (fire) begin
          cur_reg <= cmd_in;
          if (multi) state_reg <= S_WAIT;
          if (cmd_in.op == OP_DIV) begin
            state_reg    <= S_DIV;
            div_cnt_reg  <= 5'h01;
            div_qneg_reg <= cmd_in.sign_s & (div_n[31] ^ rb[15]);
            div_rneg_reg <= cmd_in.sign_s & div_n[31];
            div_den_reg  <= (cmd_in.sign_s & rb[15]) ? 16'h0000 - rb : rb;
            {div_rem_reg, div_q_reg} <= (cmd_in.sign_s & div_n[31])
                ? {1'b0, 32'h00000000 - div_n} : {1'b0, div_n};
          end
        end
        S_WAIT: state_reg <= S_RUN;
        S_DIV: if (!irq_in) begin
          div_cnt_reg <= div_cnt_reg + 5'h01;
          if (div_cnt_reg <= 5'(DIV_STEPS)) begin
            div_rem_reg <= div_try[16] ? {div_rem_reg[15:0], div_q_reg[15]}
                                       : div_try;
            div_q_reg   <= {div_q_reg[14:0], !div_try[16]};
          end
          if (div_cnt_reg == 5'(DIV_CYCLES - 1)) state_reg <= S_RUN;
        end
      endcase
    end
  end

  assign hold_pc = (rpt_cnt_reg != 16'h0000) && cx.op != OP_RPT;
  assign loop_back = (do_cnt_reg > 16'h0001) && pc_reg == do_end_reg;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pc_reg       <= '0;
      tgt_reg      <= '0;
      do_start_reg <= '0;
      do_end_reg   <= '0;
      do_cnt_reg   <= '0;
      rpt_cnt_reg  <= '0;
    end else begin
      if (fire && (cx.op == OP_BRA || cx.op == OP_CALL))
        tgt_reg <= pc_reg + {{6{cx.lit[15]}}, cx.lit, 1'b0};
      if (fire && cx.op == OP_DO) begin
        do_cnt_reg   <= cx.lit;
        do_start_reg <= pc_reg + `PC_STEP;
        do_end_reg   <= pc_reg + {6'h00, ra, 1'b0};
      end
      if (fire && cx.op == OP_RPT) rpt_cnt_reg <= cx.lit;
      else if (done && hold_pc) rpt_cnt_reg <= rpt_cnt_reg - 16'h0001;
      if (done && state_reg == S_WAIT
          && (cx.op == OP_BRA || cx.op == OP_CALL))
        pc_reg <= tgt_reg;
      else if (done && !hold_pc) begin
        if (pc_reg == do_end_reg && do_cnt_reg != 16'h0000)
          do_cnt_reg <= do_cnt_reg - 16'h0001;
        pc_reg <= loop_back ? do_start_reg : pc_reg + `PC_STEP;
      end
    end
  end

  assign apb_wr = psel_in && penable_in && pwrite_in && !err_reg;
  assign pa = paddr_in;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 16; i++) wreg_reg[i] <= '0;
    end else begin
      if (apb_wr && pa[11:6] == `A_WREG_PAGE)
        wreg_reg[pa[5:2]] <= pwdata_in[15:0];
      if (fire) begin
        unique case (cx.op)
          OP_ADD, OP_SUB: wreg_reg[cx.rd] <= res16;
          OP_LD: begin
            wreg_reg[cx.rs] <= xnext;
            wreg_reg[cx.rd] <= xdata;
          end
          OP_ST: wreg_reg[cx.rs] <= xnext;
          OP_MAC: begin
            wreg_reg[`MAC_XP_IDX] <= xnext;
            wreg_reg[`MAC_YP_IDX] <= ynext;
            wreg_reg[`MAC_XD_IDX] <= xdata;
            wreg_reg[`MAC_YD_IDX] <= y_rd_data_in;
          end
          OP_MUL: begin
            wreg_reg[cx.rd]        <= prod[15:0];
            wreg_reg[cx.rd + 4'h1] <= prod[31:16];
          end
          OP_CALL: wreg_reg[`SP_IDX] <= wreg_reg[`SP_IDX] + `WORD_BYTES;
          OP_MOVD: wreg_reg[cx.rd] <= xdata;
          default: ;
        endcase
      end
      if (state_reg == S_WAIT) begin
        unique case (cx.op)
          OP_CALL: wreg_reg[`SP_IDX] <= wreg_reg[`SP_IDX] + `WORD_BYTES;
          OP_MOVD: wreg_reg[cx.rd + 4'h1] <= xdata;
          OP_TBL:  wreg_reg[cx.rd] <= psv_data_in;
          default: ;
        endcase
      end
      if (done && state_reg == S_DIV) begin
        wreg_reg[`QUO_IDX] <= div_qneg_reg ? 16'h0000 - div_q_reg
                                           : div_q_reg;
        wreg_reg[`REM_IDX] <= div_rneg_reg ? 16'h0000 - div_rem_reg[15:0]
                                           : div_rem_reg[15:0];
      end
    end
  end

  // Return address pushed low word first
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_reg <= '0;
    end else begin
      wr_reg.en   <= fire && (cx.op == OP_ST || cx.op == OP_CALL)
                  || (state_reg == S_WAIT && cx.op == OP_CALL);
      wr_reg.addr <= (cx.op == OP_ST) ? xa : wreg_reg[`SP_IDX];
      wr_reg.data <= (cx.op == OP_ST) ? rb
                   : (state_reg == S_WAIT)
                   ? {9'h000, 7'((pc_reg + `PC_STEP) >> 16)}
                   : 16'(pc_reg + `PC_STEP);
    end
  end
  assign wr_out = wr_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_reg <= `CTRL_RESET;
      xmod_reg <= '0;
      ymod_reg <= '0;
      agu_reg  <= '0;
    end else if (apb_wr) begin
      if (pa == `A_CTRL) ctrl_reg <= pwdata_in[15:0];
      if (pa == `A_XMOD) xmod_reg <= pwdata_in;
      if (pa == `A_YMOD) ymod_reg <= pwdata_in;
      if (pa == `A_AGU)  agu_reg  <= pwdata_in;
    end
  end

  // Datapath updates follow the bus write so hardware wins a tie
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      {ovf_a_reg, ovf_b_reg, sat_a_reg, sat_b_reg} <= 4'h0;
      {dc_reg, n_reg, ov_reg, z_reg, c_reg} <= 5'h00;
      ipl_reg <= 3'h0;
    end else begin
      if (apb_wr && pa == `A_STATUS) begin
        if (!pwdata_in[`SR_SA] || !pwdata_in[`SR_SAB]) sat_a_reg <= 1'b0;
        if (!pwdata_in[`SR_SB] || !pwdata_in[`SR_SAB]) sat_b_reg <= 1'b0;
        if (!ctrl_reg[`CT_NESTING_DISABLE]) ipl_reg <= pwdata_in[`SR_IPL];
        dc_reg <= pwdata_in[`SR_DC];
        n_reg  <= pwdata_in[`SR_N];
        ov_reg <= pwdata_in[`SR_OV];
        z_reg  <= pwdata_in[`SR_Z];
        c_reg  <= pwdata_in[`SR_C];
      end
      if (acc_op && cx.acc_b) ovf_b_reg <= acc_ovf;
      if (acc_op && !cx.acc_b) ovf_a_reg <= acc_ovf;
      if (acc_sat && acc_op && cx.acc_b) sat_b_reg <= 1'b1;
      if (acc_sat && acc_op && !cx.acc_b) sat_a_reg <= 1'b1;
      if (fire && (cx.op == OP_ADD || cx.op == OP_SUB)) begin
        dc_reg <= cx.byte_mode ? cxv[4] : cxv[8];
        c_reg  <= cx.byte_mode ? cxv[8] : sum[16];
        n_reg  <= cx.byte_mode ? sum[7] : sum[15];
        z_reg  <= cx.byte_mode ? (sum[7:0] == 8'h00) : (sum[15:0] == '0);
        ov_reg <= cx.byte_mode ? (ra[7] == beff[7] && sum[7] != ra[7])
                               : (ra[15] == beff[15] && sum[15] != ra[15]);
      end
    end
  end

  assign sr = {ovf_a_reg, ovf_b_reg, sat_a_reg, sat_b_reg,
               ovf_a_reg | ovf_b_reg, sat_a_reg | sat_b_reg,
               do_cnt_reg != 16'h0000, dc_reg, ipl_reg,
               rpt_cnt_reg != 16'h0000, n_reg, ov_reg, z_reg, c_reg};
  assign cpu_status_word_out = sr;
  assign cpu_priority_level_out = {ctrl_reg[`CT_PRIORITY_LEVEL_MSB], ipl_reg};
  assign user_irq_enable_out = !ctrl_reg[`CT_PRIORITY_LEVEL_MSB];

  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    unique case (pa)
      `A_STATUS:  rd_val = {16'h0000, sr};
      `A_CTRL:    rd_val = {16'h0000, ctrl_reg};
      `A_PC:      rd_val = {9'h000, pc_reg};
      `A_XMOD:    rd_val = xmod_reg;
      `A_YMOD:    rd_val = ymod_reg;
      `A_AGU:     rd_val = agu_reg;
      `A_ACCA_LO: rd_val = acc_a_reg[31:0];
      `A_ACCA_HI: rd_val = {24'h000000, acc_a_reg[39:32]};
      `A_ACCB_LO: rd_val = acc_b_reg[31:0];
      `A_ACCB_HI: rd_val = {24'h000000, acc_b_reg[39:32]};
      default: begin
        rd_hit = (pa[11:6] == `A_WREG_PAGE) && pa[1:0] == 2'h0;
        rd_val = {16'h0000, wreg_reg[pa[5:2]]};
      end
    endcase
  end

  // Decoded in setup so the access phase answers at once
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prdata_reg <= '0;
      err_reg    <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_reg <= rd_hit ? rd_val : 32'h00000000;
      err_reg    <= !rd_hit;
    end
  end
  assign prdata_out  = prdata_reg;
  assign pready_out  = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && err_reg;

endmodule
`default_nettype wire

/* File: hdl/dsc_core_params.svh */
`ifndef DSC_CORE_PARAMS_SVH
`define DSC_CORE_PARAMS_SVH

// Datapath widths and fixed register roles
`define PC_W        23
`define ACC_W       40
`define SP_IDX      4'hf
`define MAC_XD_IDX  4'h4
`define MAC_YD_IDX  4'h6
`define MAC_XP_IDX  4'h8
`define MAC_YP_IDX  4'ha
`define QUO_IDX     4'h0
`define REM_IDX     4'h1
`define WORD_BYTES  16'h0002
`define PC_STEP     23'h000002
`define DIV_CYCLES  19
`define DIV_STEPS   16
`define SAT_POS     40'h007fffffff
`define SAT_NEG     40'hff80000000

// APB byte addresses
`define A_STATUS    12'h000
`define A_CTRL      12'h004
`define A_PC        12'h008
`define A_XMOD      12'h00c
`define A_YMOD      12'h010
`define A_AGU       12'h014
`define A_ACCA_LO   12'h018
`define A_ACCA_HI   12'h01c
`define A_ACCB_LO   12'h020
`define A_ACCB_HI   12'h024
`define A_WREG_PAGE 6'h01

// Status word fields
`define SR_SA       13
`define SR_SB       12
`define SR_SAB      10
`define SR_DC       8
`define SR_IPL      7:5
`define SR_N        3
`define SR_OV       2
`define SR_Z        1
`define SR_C        0

// Control register fields
`define CT_SAT_A    0
`define CT_SAT_B    1
`define CT_FRAC     2
`define CT_PSV      3
`define CT_PRIORITY_LEVEL_MSB     4
`define CT_NESTING_DISABLE   5
`define CT_PAGE     15:8
`define CTRL_RESET  16'h0000

// Address generator fields
`define MOD_START   15:0
`define MOD_END     31:16
`define AG_XMOD     0
`define AG_YMOD     1
`define AG_BREV     2
`define AG_BMOD     31:16

`endif

/* File: hdl/dsc_core_pkg.sv */
package dsc_core_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_LD, OP_ST, OP_MAC, OP_MUL, OP_SFT,
    OP_DIV, OP_DO, OP_RPT, OP_BRA, OP_CALL, OP_MOVD, OP_TBL
  } op_e;

  typedef enum logic [1:0] {S_RUN, S_WAIT, S_DIV} core_state_e;

  typedef struct packed {
    op_e         op;
    logic        byte_mode;  // 8-bit ALU op
    logic        acc_b;      // target accumulator B
    logic        sign_s;     // rs operand signed
    logic        sign_t;     // rt operand signed
    logic        wide;       // 32/16 divide
    logic [3:0]  rd;
    logic [3:0]  rs;
    logic [3:0]  rt;
    logic [15:0] lit;
  } cmd_s;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_wr_s;

endpackage

/* File: tb/dsc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_mem_model (
  input  wire logic [15:0] x_addr_in,  // X address
  input  wire logic [15:0] y_addr_in,  // Y address
  input  wire logic [22:0] p_addr_in,  // Program address
  output logic      [15:0] x_data_out, // X data
  output logic      [15:0] y_data_out, // Y data
  output logic      [15:0] p_data_out  // Program data
);
  assign x_data_out = x_addr_in ^ 16'h1234;
  assign y_data_out = y_addr_in ^ 16'h4321;
  assign p_data_out = p_addr_in[15:0] ^ 16'h0f0f;
endmodule
`default_nettype wire

/* File: tb/dsc_cpu_status_datapath_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_status_checker import dsc_core_pkg::*; #(
  parameter int DIV_CYCLES = 19
) (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        cmd_valid_in,
  input wire cmd_s        cmd_in,
  input wire logic        cmd_ready_out,
  input wire logic        irq_in,
  input wire logic [22:0] fetch_addr_out,
  input wire logic [15:0] cpu_status_word_out,
  input wire logic [3:0]  cpu_priority_level_out,
  input wire logic        user_irq_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic [15:0] st;
  logic [4:0]  stall_cnt;
  logic        irq_seen;
  logic        sr_wr;
  assign st = cpu_status_word_out;
  // Op edges excluded: a hardware set may beat the clear
  assign sr_wr = psel_in && penable_in && pwrite_in &&
                 paddr_in == 12'h000 && !cmd_valid_in;
  always_ff @(posedge clk_in) begin
    if (!rstn_in || cmd_ready_out) begin
      stall_cnt <= 5'h00;
      irq_seen  <= 1'b0;
    end else begin
      stall_cnt <= stall_cnt + 5'h01;
      irq_seen  <= irq_seen | irq_in;
    end
  end
  sequence stall_end_s;
    $rose(cmd_ready_out) && !irq_seen;
  endsequence
  sequence add_go_s;
    cmd_valid_in && cmd_ready_out && cmd_in.op == OP_ADD && !st[4] && !st[9];
  endsequence
  ovf_join_a: assert property (st[11] == (st[15] | st[14]))
    else $error("combined overflow bit wrong");
  clip_join_a: assert property (st[10] == (st[13] | st[12]))
    else $error("combined clip bit wrong");
  clip_wipe_a: assert property (sr_wr && !pwdata_in[10] |=> st[13:12] == 2'b00)
    else $error("clip flags survived clear");
  prio_join_a: assert property (cpu_priority_level_out[2:0] == st[7:5] &&
    user_irq_enable_out == !cpu_priority_level_out[3])
    else $error("priority level wrong");
  ro_bits_a: assert property (sr_wr |=> $stable({st[15:14], st[9], st[4]}))
    else $error("read-only status bit written");
  clear_only_a: assert property (sr_wr |=> (st[13:12] & ~$past(st[13:12])) == 2'b00)
    else $error("sticky flag set by write");
  pc_step_a: assert property (add_go_s |=> fetch_addr_out == $past(fetch_addr_out) + 23'h2)
    else $error("pc step wrong");
  stall_len_a: assert property (stall_end_s |-> stall_cnt == 5'h01 ||
    stall_cnt == 5'(DIV_CYCLES - 1))
    else $error("stall length wrong");
endmodule
bind dsc_cpu_status_datapath dsc_status_checker #(.DIV_CYCLES(DIV_CYCLES)) u_chk (
  .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .cmd_valid_in, .cmd_in, .cmd_ready_out, .irq_in, .fetch_addr_out,
  .cpu_status_word_out, .cpu_priority_level_out, .user_irq_enable_out);
`default_nettype wire

/* File: tb/dsc_cpu_status_datapath_test.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_cpu_status_datapath_test import dsc_core_pkg::*; ;
  logic        clk_in, rstn, psel, penable, pwrite, cmd_valid, irq;
  logic        pready, pslverr, cmd_ready, user_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] xa, ya, xd, yd, pd, sr, op_lit;
  logic [22:0] pa;
  logic [3:0]  prio;
  cmd_s        cmd;
  mem_wr_s     mem_wr;
  int          miscompares, checks_done, n;
  op_e         two_ops[4] = '{OP_BRA, OP_MOVD, OP_TBL, OP_CALL};
  logic [15:0] ma[4] = '{16'hffff, 16'hffff, 16'hffff, 16'h8000};
  logic [3:0]  mf[4] = '{4'b0011, 4'b0000, 4'b0010, 4'b0011};
  logic [31:0] mp[4] = '{32'h1, 32'hfffe0001, 32'hffff0001, 32'h40000000};
  dsc_cpu_status_datapath u_dsc_cpu_status_datapath (
    .clk_in(clk_in), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .irq_in(irq), .fetch_addr_out(), .x_rd_addr_out(xa), .x_rd_data_in(xd),
    .y_rd_addr_out(ya), .y_rd_data_in(yd), .psv_addr_out(pa),
    .psv_data_in(pd), .wr_out(mem_wr), .cpu_status_word_out(sr),
    .cpu_priority_level_out(prio), .user_irq_enable_out(user_en));
  dsc_mem_model u_dsc_mem_model (.x_addr_in(xa), .y_addr_in(ya),
    .p_addr_in(pa), .x_data_out(xd), .y_data_out(yd), .p_data_out(pd));
  function automatic logic [11:0] wa(input logic [3:0] i);
    return {6'h01, i, 2'b00};
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) miscompares++;
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rdata);
  endtask
  // Returns cycles until the core takes the next op
  task automatic op(input op_e o, input logic [3:0] d, s, t, f);
    cmd       <= {o, f, 1'b0, d, s, t, op_lit};
    cmd_valid <= 1'b1;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    if (cmd_ready !== 1'b1) miscompares++;
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (10000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {rstn, psel, penable, pwrite, cmd_valid, irq} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    cmd = '0;
    op_lit = 16'h0000;
    repeat (5) @(posedge clk_in);
    rstn <= 1'b1;
    @(posedge clk_in);
    rd("sr_reset", 12'h000, 32'h0);
    rd("unmapped", 12'hffc, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    wr(12'h000, 32'hffff);
    rd("sr_rw", 12'h000, 32'h01ef);
    chk("prio", 32'h7, 32'({user_en, prio} ^ 5'h10));
    wr(12'h004, 32'h30);
    wr(12'h000, 32'h0);
    rd("sr_nest", 12'h000, 32'h00e0);
    chk("prio_top", 32'hf, 32'({user_en, prio}));
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0);
    wr(wa(1), 32'h000f);
    wr(wa(2), 32'h0001);
    op(OP_ADD, 4'h3, 4'h1, 4'h2, 4'b1000);
    chk("dc_byte", 32'h1, 32'(sr[8]));
    wr(wa(1), 32'hffff);
    op(OP_ADD, 4'h3, 4'h1, 4'h2, 4'b0000);
    chk("dc_c_word", 32'h3, 32'({sr[8], sr[0]}));
    rd("add_sum", wa(3), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(wa(1), 32'(ma[i]));
      wr(wa(2), 32'(ma[i]));
      op(OP_MUL, 4'h4, 4'h1, 4'h2, mf[i]);
      rd("mul_lo", wa(4), 32'(mp[i][15:0]));
      rd("mul_hi", wa(5), 32'(mp[i][31:16]));
    end
    foreach (two_ops[i]) begin
      op(two_ops[i], 4'h7, 4'h1, 4'h2, 4'b0000);
      chk("two_cycle", 32'd2, 32'(n));
    end
    // Second push of the call: high word at stack pointer plus two
    chk("push_hi", 32'h80020000, {mem_wr.en, mem_wr.addr[14:0], mem_wr.data});
    for (int i = 0; i < 2; i++) begin
      wr(wa(2), 32'd100);
      wr(wa(1), 32'd7);
      irq <= i[0];
      fork
        begin
          repeat (4) @(posedge clk_in);
          irq <= 1'b0;
        end
      join_none
      op(OP_DIV, 4'h0, 4'h2, 4'h1, 4'b0000);
      chk("div_len", 32'(19 + 3 * i), 32'(n));
      rd("div_quo", wa(0), 32'd14);
      rd("div_rem", wa(1), 32'd2);
    end
    wr(12'h004, 32'h05);
    wr(wa(1), 32'h7fff);
    wr(wa(2), 32'h7fff);
    wr(wa(8), 32'h0000);
    repeat (2) op(OP_MAC, 4'h0, 4'h1, 4'h2, 4'b0011);
    chk("sat_a", 32'h3, 32'({sr[13], sr[10]}));
    rd("acca", 12'h018, 32'h7fffffff);
    rd("x_pair", wa(4), 32'h1236);
    rd("y_pair", wa(6), 32'h4323);
    repeat (2) op(OP_MAC, 4'h0, 4'h1, 4'h2, 4'b0111);
    chk("ovf_b", 32'h3, 32'({sr[14], sr[11]}));
    wr(12'h000, 32'h0);
    rd("sr_wipe", 12'h000, 32'hc800);
    op_lit = 16'h0002;
    op(OP_RPT, 4'h0, 4'h0, 4'h0, 4'b0000);
    chk("rpt_flag", 32'h1, 32'(sr[4]));
    op_lit = 16'h0000;
    repeat (2) op(OP_NOP, 4'h0, 4'h0, 4'h0, 4'b0000);
    chk("rpt_done", 32'h0, 32'(sr[4]));
    op_lit = 16'h0003;
    op(OP_DO, 4'h0, 4'h1, 4'h0, 4'b0000);
    chk("do_flag", 32'h1, 32'(sr[9]));
    tally_and_finish();
  end
endmodule
`default_nettype wire
